// file: logic/kw_matcher.sv
/*
  Combinational keyword matcher: compares a folded keyword against the
  keyword table in long and short form.
  Assumes the caller holds the keyword, first character in the low byte.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scpi_params.svh"

module kw_matcher (
  input wire logic [8*`KW_MAX-1:0] kw_flat_in,
  input wire logic [`KW_LEN_W-1:0] kw_len_in,
  output logic hit_out,
  output logic [`KW_IDX_W-1:0] index_out
);

  // Long forms, right aligned: first letter in the highest used byte
  localparam logic [8*`KW_MAX-1:0] KW_TEXT [`KW_COUNT] = '{
    "VOLTAGE", "CURRENT", "MEASURE", "LEVEL",
    "IMMEDIATE", "STATUS", "MODE", "DIAGNOSTIC"
  };
  localparam logic [`KW_LEN_W-1:0] KW_LEN [`KW_COUNT] = '{
    4'h7, 4'h7, 4'h7, 4'h5, 4'h9, 4'h6, 4'h4, 4'ha
  };
  localparam logic [`KW_COUNT-1:0] KW_LONG_ONLY = 8'h80;

  function automatic logic [`KW_LEN_W-1:0] short_len(
    input logic [8*`KW_MAX-1:0] w,
    input logic [`KW_LEN_W-1:0] l
  );
    logic [7:0] c4;
    c4 = 8'h00;
    if (l <= 4'h4) begin
      short_len = l;
    end else begin
      c4 = w[8*(int'(l)-4) +: 8];
      if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U") begin
        short_len = 4'h3;
      end else begin
        short_len = 4'h4;
      end
    end
  endfunction

  logic [`KW_COUNT-1:0] ok;

  for (genvar e = 0; e < `KW_COUNT; e++) begin : g_ent
    logic eq;
    always_comb begin
      eq = 1'b1;
      for (int j = 0; j < `KW_MAX; j++) begin
        if (j < int'(kw_len_in) && j < int'(KW_LEN[e])) begin
          if (kw_flat_in[8*j +: 8] !=
              KW_TEXT[e][8*(int'(KW_LEN[e])-1-j) +: 8]) begin
            eq = 1'b0;
          end
        end
      end
    end
    // whole short or whole long form only
    // long-only entries refuse the short form
    assign ok[e] = eq && (kw_len_in == KW_LEN[e] || (!KW_LONG_ONLY[e] &&
                   kw_len_in == short_len(KW_TEXT[e], KW_LEN[e])));
  end

  always_comb begin
    hit_out = 1'b0;
    index_out = '0;
    for (int e = `KW_COUNT-1; e >= 0; e--) begin
      if (ok[e]) begin
        hit_out = 1'b1;
        index_out = e[`KW_IDX_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/scpi_message_parser.sv
/*
  Program message parser: splits a character stream into keywords,
  queries, data characters, unit and message ends, with error reporting.
  Assumes the character source runs on core_clk_in and offers at most
  one character per cycle; no back-pressure is needed.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scpi_params.svh"

// Function
// - A character received with end-of-line asserted terminates the message.
// - One data parameter may follow the keyword after a single space.
// - Extra spaces outside double quotes are a syntax error.
// - A keyword ends only on space, comma, semicolon, colon, ?, newline or end-of-line.
// - Short form is whole word, or first four, or three if fourth vowel.
// - Only the exact short or long form matches; others are errors.
// - Some keywords accept only their long form.
// - Lower-case letters are folded to upper case before matching.
// - Characters inside double quotes pass without case folding.
// - A colon between keywords separates them.
// - A question mark after the last keyword makes a query.
// - A semicolon marks the boundary between message units.
// - Newline completes the message and returns to the tree root.
// - A colon before a unit's first keyword is a root specifier.
module scpi_message_parser (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  input wire logic eol_in,
  output var scpi_pkg::unit_evt_t unit_out,
  output logic error_out
);

  scpi_pkg::parse_state_t state_r, state_nxt;
  logic [7:0] kw_buf_r [`KW_MAX];
  logic [7:0] kw_buf_nxt [`KW_MAX];
  logic [`KW_LEN_W-1:0] kw_len_r, kw_len_nxt;
  logic unit_start_r, unit_start_nxt;
  logic need_kw_r, need_kw_nxt;
  logic data_any_r, data_any_nxt;
  logic in_quote_r, in_quote_nxt;
  scpi_pkg::unit_evt_t unit_r, unit_nxt;
  logic error_r, error_nxt;
  logic [8*`KW_MAX-1:0] kw_flat;
  logic match_hit;
  logic [`KW_IDX_W-1:0] match_idx;
  logic term, fin, fin_query, kw_char;
  logic [7:0] c;

  for (genvar i = 0; i < `KW_MAX; i++) begin : g_flat
    assign kw_flat[8*i +: 8] = kw_buf_r[i];
  end

  kw_matcher u_match (
    .kw_flat_in(kw_flat),
    .kw_len_in(kw_len_r),
    .hit_out(match_hit),
    .index_out(match_idx)
  );

  // end-of-line flag counts as a newline
  assign term = (char_in == `CHAR_NL) || eol_in;

  assign c = (!in_quote_r && char_in >= "a" && char_in <= "z") ?
             char_in - `CASE_DELTA : char_in;

  assign kw_char = (c >= "A" && c <= "Z") || (c >= "0" && c <= "9") ||
                   (c == `CHAR_STAR);

  always_comb begin
    state_nxt = state_r;
    kw_buf_nxt = kw_buf_r;
    kw_len_nxt = kw_len_r;
    unit_start_nxt = unit_start_r;
    need_kw_nxt = need_kw_r;
    data_any_nxt = data_any_r;
    in_quote_nxt = in_quote_r;
    unit_nxt = '0;
    error_nxt = 1'b0;
    fin = 1'b0;
    fin_query = 1'b0;
    if (char_valid_in) begin
      if (term) begin
        // back to root after the message
        unit_nxt.msg_end = 1'b1;
        state_nxt = scpi_pkg::ST_KEY;
        kw_len_nxt = '0;
        unit_start_nxt = 1'b1;
        need_kw_nxt = 1'b0;
        data_any_nxt = 1'b0;
        in_quote_nxt = 1'b0;
        case (state_r)
          scpi_pkg::ST_KEY: begin
            if (kw_len_r != '0) begin
              fin = 1'b1;
              unit_nxt.unit_end = 1'b1;
            end else if (need_kw_r) begin
              error_nxt = 1'b1;
            end
          end
          scpi_pkg::ST_DATA: begin
            unit_nxt.unit_end = 1'b1;
            error_nxt = !data_any_r || in_quote_r;
          end
          scpi_pkg::ST_QUERY: begin
            unit_nxt.unit_end = 1'b1;
          end
          default: begin
          end
        endcase
      end else begin
        case (state_r)
          scpi_pkg::ST_KEY: begin
            // only listed characters close a keyword
            if (kw_char) begin
              if (kw_len_r == 4'(`KW_MAX)) begin
                error_nxt = 1'b1;
              end else begin
                kw_buf_nxt[kw_len_r] = c;
                kw_len_nxt = kw_len_r + 4'h1;
                unit_start_nxt = 1'b0;
                need_kw_nxt = 1'b0;
              end
            end else if (c == `CHAR_COLON) begin
              if (kw_len_r != '0) begin
                fin = 1'b1;
                need_kw_nxt = 1'b1;
              end else if (unit_start_r && !need_kw_r) begin
                unit_nxt.root = 1'b1;
                unit_start_nxt = 1'b0;
                need_kw_nxt = 1'b1;
              end else begin
                error_nxt = 1'b1;
              end
            end else if (c == `CHAR_QMARK && kw_len_r != '0) begin
              fin = 1'b1;
              fin_query = 1'b1;
              state_nxt = scpi_pkg::ST_QUERY;
            end else if ((c == `CHAR_SPACE || c == `CHAR_COMMA) &&
                         kw_len_r != '0) begin
              // single space leads to the parameter
              fin = 1'b1;
              data_any_nxt = 1'b0;
              state_nxt = scpi_pkg::ST_DATA;
            end else if (c == `CHAR_SEMI && kw_len_r != '0) begin
              fin = 1'b1;
              unit_nxt.unit_end = 1'b1;
              unit_start_nxt = 1'b1;
            end else begin
              error_nxt = 1'b1;
            end
          end
          scpi_pkg::ST_QUERY: begin
            if (c == `CHAR_SPACE) begin
              data_any_nxt = 1'b0;
              state_nxt = scpi_pkg::ST_DATA;
            end else if (c == `CHAR_SEMI) begin
              unit_nxt.unit_end = 1'b1;
              unit_start_nxt = 1'b1;
              state_nxt = scpi_pkg::ST_KEY;
            end else begin
              error_nxt = 1'b1;
            end
          end
          scpi_pkg::ST_DATA: begin
            if (in_quote_r) begin
              unit_nxt.data_valid = 1'b1;
              unit_nxt.data_char = c;
              in_quote_nxt = (c != `CHAR_QUOTE);
            end else if (c == `CHAR_SPACE) begin
              // no spaces beyond the single separator
              error_nxt = 1'b1;
            end else if (c == `CHAR_SEMI) begin
              unit_nxt.unit_end = data_any_r;
              error_nxt = !data_any_r;
              unit_start_nxt = 1'b1;
              state_nxt = scpi_pkg::ST_KEY;
            end else begin
              unit_nxt.data_valid = 1'b1;
              unit_nxt.data_char = c;
              data_any_nxt = 1'b1;
              in_quote_nxt = (c == `CHAR_QUOTE);
            end
          end
          default: begin
          end
        endcase
      end
      if (fin) begin
        unit_nxt.kw_valid = 1'b1;
        unit_nxt.kw_index = match_idx;
        unit_nxt.query = fin_query;
        kw_len_nxt = '0;
        error_nxt = error_nxt || !match_hit;
      end
      // report once, then drop the rest of the message
      if (error_nxt) begin
        unit_nxt = '0;
        unit_nxt.msg_end = term;
        state_nxt = term ? scpi_pkg::ST_KEY : scpi_pkg::ST_DISCARD;
        in_quote_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_r <= scpi_pkg::ST_KEY;
      for (int i = 0; i < `KW_MAX; i++) begin
        kw_buf_r[i] <= 8'h00;
      end
      kw_len_r <= '0;
      unit_start_r <= 1'b1;
      need_kw_r <= 1'b0;
      data_any_r <= 1'b0;
      in_quote_r <= 1'b0;
      unit_r <= '0;
      error_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kw_buf_r <= kw_buf_nxt;
      kw_len_r <= kw_len_nxt;
      unit_start_r <= unit_start_nxt;
      need_kw_r <= need_kw_nxt;
      data_any_r <= data_any_nxt;
      in_quote_r <= in_quote_nxt;
      unit_r <= unit_nxt;
      error_r <= error_nxt;
    end
  end

  assign unit_out = unit_r;
  assign error_out = error_r;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_data_space;
    char_valid_in && !eol_in && char_in == `CHAR_SPACE &&
    state_r == scpi_pkg::ST_DATA && !in_quote_r;
  endsequence

  sequence s_key_open;
    char_valid_in && !eol_in && char_in == `CHAR_COLON &&
    state_r == scpi_pkg::ST_KEY && kw_len_r == '0 &&
    unit_start_r && !need_kw_r;
  endsequence

  a_eol_ends_msg: assert property (
    char_valid_in && eol_in |=> unit_out.msg_end && state_r == scpi_pkg::ST_KEY)
    else $error("end-of-line did not end the message");

  a_nl_ends_msg: assert property (
    char_valid_in && char_in == `CHAR_NL |=> unit_out.msg_end && unit_start_r)
    else $error("newline did not return to root");

  a_extra_space: assert property (
    s_data_space |=> error_out && state_r == scpi_pkg::ST_DISCARD)
    else $error("extra space was tolerated");

  a_root_colon: assert property (
    s_key_open |=> unit_out.root && need_kw_r && !error_out)
    else $error("root specifier not reported");

  a_query_kw: assert property (
    unit_out.query |-> unit_out.kw_valid && state_r == scpi_pkg::ST_QUERY)
    else $error("query without keyword");

  a_discard_quiet: assert property (
    state_r == scpi_pkg::ST_DISCARD && char_valid_in && !term
    |=> !unit_out.kw_valid && !unit_out.data_valid && !error_out &&
    state_r == scpi_pkg::ST_DISCARD)
    else $error("output while discarding");

  a_miss_error: assert property (
    char_valid_in && fin && !match_hit |=> error_out && !unit_out.kw_valid)
    else $error("unmatched keyword accepted");

  a_fold_data: assert property (
    char_valid_in && !eol_in && state_r == scpi_pkg::ST_DATA &&
    !in_quote_r && char_in >= "a" && char_in <= "z"
    |=> unit_out.data_valid && unit_out.data_char == $past(char_in) - 8'h20)
    else $error("lower case not folded");

  a_quote_raw: assert property (
    char_valid_in && state_r == scpi_pkg::ST_DATA && in_quote_r && !term
    |=> unit_out.data_valid && unit_out.data_char == $past(char_in))
    else $error("quoted character altered");

  a_semi_unit: assert property (
    char_valid_in && char_in == `CHAR_SEMI && kw_len_r != '0 &&
    state_r == scpi_pkg::ST_KEY |=> ((unit_out.kw_valid &&
    unit_out.unit_end) || error_out) ##1 !unit_out.kw_valid)
    else $error("semicolon did not close the unit");

endmodule
`default_nettype wire

// file: logic/scpi_params.svh
/*
  Character codes and sizes for the program message parser.
  Assumes 8-bit characters on the input stream.
*/
`ifndef SCPI_PARAMS_SVH
`define SCPI_PARAMS_SVH

`define CHAR_NL 8'h0a
`define CHAR_SPACE 8'h20
`define CHAR_QUOTE 8'h22
`define CHAR_STAR 8'h2a
`define CHAR_COMMA 8'h2c
`define CHAR_COLON 8'h3a
`define CHAR_SEMI 8'h3b
`define CHAR_QMARK 8'h3f
`define CASE_DELTA 8'h20
`define KW_MAX 10
`define KW_COUNT 8
`define KW_LEN_W 4
`define KW_IDX_W 3

`endif

// file: logic/scpi_pkg.sv
/*
  Types shared by the program message parser and its keyword matcher.
  Assumes scpi_params.svh is on the include path.
*/
`default_nettype none
`include "scpi_params.svh"

package scpi_pkg;

  typedef enum logic [1:0] {
    ST_KEY = 2'b00,
    ST_DATA = 2'b01,
    ST_QUERY = 2'b11,
    ST_DISCARD = 2'b10
  } parse_state_t;

  typedef struct packed {
    logic kw_valid;
    logic [`KW_IDX_W-1:0] kw_index;
    logic query;
    logic root;
    logic data_valid;
    logic [7:0] data_char;
    logic unit_end;
    logic msg_end;
  } unit_evt_t;

endpackage
`default_nettype wire

// file: verification/host_sender.sv
/*
  Host controller model: sends program message characters to the parser.
  Assumes the bench queues messages through send(), whole or cut short by a reset.
*/
`timescale 1ns/1ns
`default_nettype none
module host_sender (
  input wire logic core_clk_in,
  output logic char_valid_out,
  output logic [7:0] char_out,
  output logic eol_out
);
  logic [8:0] q[$];
  int gap = 0;
  int wait_cnt = 0;
  initial begin
    char_valid_out = 1'b0;
    char_out = 8'h00;
    eol_out = 1'b0;
  end
  task automatic send(input string s, input bit eol_last, input int slow);
    for (int i = 0; i < s.len(); i++) begin
      q.push_back({eol_last && i == s.len() - 1, s[i]});
    end
    gap = slow;
  endtask
  function automatic bit idle();
    return q.size() == 0;
  endfunction
  // End-of-line rides with a valid character
  always @(posedge core_clk_in) begin
    if (q.size() != 0 && wait_cnt == 0) begin
      char_valid_out <= 1'b1;
      {eol_out, char_out} <= q.pop_front();
      wait_cnt <= gap;
    end else begin
      // Idle lines toggle so no stale value looks valid
      char_valid_out <= 1'b0;
      char_out <= ~char_out;
      eol_out <= ~eol_out;
      if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
/*
  Self-checking bench for the program message parser.
  Assumes the host model feeds characters; outputs are collected per cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef logic [17:0] obs_t;
  localparam obs_t UE = 18'h00002;
  localparam obs_t ME = 18'h00001;
  localparam obs_t RT = 18'h00800;
  localparam obs_t ER = 18'h20000;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic char_valid_in;
  logic [7:0] char_in;
  logic eol_in;
  scpi_pkg::unit_evt_t unit_out;
  logic error_out;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  obs_t seen[$];
  int seen_cyc[$];

  always #4 core_clk_in = ~core_clk_in;

  scpi_message_parser i_scpi_message_parser (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .char_valid_in(char_valid_in),
    .char_in(char_in),
    .eol_in(eol_in),
    .unit_out(unit_out),
    .error_out(error_out)
  );

  host_sender i_host_sender (
    .core_clk_in(core_clk_in),
    .char_valid_out(char_valid_in),
    .char_out(char_in),
    .eol_out(eol_in)
  );

  // Unknowns differ from zero, so they are collected and fail
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (!reset_in && {error_out, unit_out} !== 18'h00000) begin
      seen.push_back({error_out, unit_out});
      seen_cyc.push_back(cyc);
    end
  end

  function automatic obs_t K(input logic [2:0] ix, input logic q);
    return {2'b01, ix, q, 12'h000};
  endfunction
  function automatic obs_t D(input logic [7:0] c);
    return {7'h00, 1'b1, c, 2'b00};
  endfunction
  function automatic string short_form(input string w);
    if (w.len() <= 4) return w;
    if (w[3] inside {"A", "E", "I", "O", "U"}) return w.substr(0, 2);
    return w.substr(0, 3);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input obs_t got, input obs_t exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input string s, input bit eol, input int slow,
                     input obs_t exp[$]);
    int n;
    seen.delete();
    seen_cyc.delete();
    i_host_sender.send(s, eol, slow);
    n = 0;
    while (!i_host_sender.idle() && n < 400) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      end_sim();
    end
    repeat (6) @(posedge core_clk_in);
    check({s, " count"}, obs_t'(seen.size()), obs_t'(exp.size()));
    foreach (exp[i]) check(s, seen[i], exp[i]);
  endtask

  task automatic t_walk();
    run("VOLT 5\n", 0, 0, '{K(0, 0), D(8'h35), UE | ME});
    check("spacing", obs_t'(seen_cyc[2] - seen_cyc[0]), 18'h00002);
    $display("test walk done");
  endtask

  task automatic t_case();
    run("curr?\n", 0, 0, '{K(1, 1), UE | ME});
    run("MeAsUrE:LeVeL?\n", 0, 0, '{K(2, 0), K(3, 1), UE | ME});
    $display("test case done");
  endtask

  task automatic t_units();
    run(":MEAS:VOLT?;:CURR 1\n", 0, 0, '{RT, K(2, 0), K(0, 1), UE, RT,
        K(1, 0), D(8'h31), UE | ME});
    run("DIAGNOSTIC:MODE \"p\";:STAT?\n", 0, 0, '{K(7, 0), K(6, 0),
        D(8'h22), D(8'h70), D(8'h22), UE, RT, K(5, 1), UE | ME});
    $display("test units done");
  endtask

  task automatic t_forms();
    string w[8] = '{"VOLTAGE", "CURRENT", "MEASURE", "LEVEL",
                    "IMMEDIATE", "STATUS", "MODE", "DIAGNOSTIC"};
    for (int i = 0; i < 8; i++) begin
      run({w[i], "\n"}, 0, 0, '{K(3'(i), 0) | UE | ME});
      run({short_form(w[i]), "\n"}, 0, 0,
          '{i == 7 ? ER | ME : K(3'(i), 0) | UE | ME});
    end
    run("VOLTA\n", 0, 0, '{ER | ME});
    run("IMME\n", 0, 0, '{ER | ME});
    $display("test forms done");
  endtask

  task automatic t_quote();
    run("MODE x\"a b\"\n", 0, 0, '{K(6, 0), D(8'h58), D(8'h22), D(8'h61),
        D(8'h20), D(8'h62), D(8'h22), UE | ME});
    $display("test quote done");
  endtask

  task automatic t_errors();
    run("VOLT  5;CURR 1\n", 0, 0, '{K(0, 0), ER, ME});
    run("VOLT 5 \n", 0, 0, '{K(0, 0), D(8'h35), ER, ME});
    run("VO#LT\n", 0, 0, '{ER, ME});
    run("VOLT,5;CURR\n", 0, 0, '{K(0, 0), D(8'h35), UE,
        K(1, 0) | UE | ME});
    run("LEV:\n", 0, 0, '{K(3, 0), ER | ME});
    run("CURR? MAX\n", 0, 0, '{K(1, 1), D(8'h4d), D(8'h41), D(8'h58),
        UE | ME});
    run("VOLTAGEVOLT\n", 0, 0, '{ER, ME});
    run("MODE \"ab\n", 0, 0, '{K(6, 0), D(8'h22), D(8'h61), D(8'h62),
        ER | ME});
    run("MODE;;\n", 0, 0, '{K(6, 0) | UE, ER, ME});
    $display("test errors done");
  endtask

  task automatic t_eol();
    run("MODEQ", 1, 2, '{K(6, 0) | UE | ME});
    // Reset in mid-message must leave no stale keyword behind
    i_host_sender.send("VOLT", 0, 0);
    repeat (8) @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    run("CURR\n", 0, 0, '{K(1, 0) | UE | ME});
    $display("test eol done");
  endtask

  initial begin
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    t_walk();
    t_case();
    t_units();
    t_forms();
    t_quote();
    t_errors();
    t_eol();
    end_sim();
  end
endmodule
`default_nettype wire
